// file: rtl/hostmisc_pkg.sv
/*
  Shared constants for the host engine miscellaneous and buffer-size
  register bank: command codes, field positions, reset values.
  Assumes a 16-bit command/data register port on the system clock.
*/
package hostmisc_pkg;
  // Command codes (read and write)
  localparam logic [7:0] CMD_ID_RD = 8'h27;
  localparam logic [7:0] CMD_SCRATCH_RD = 8'h28;
  localparam logic [7:0] CMD_SCRATCH_WR = 8'hA8;
  localparam logic [7:0] CMD_SOFT_RESET_WR = 8'hA9;
  localparam logic [7:0] CMD_ISO_SIZE_RD = 8'h2A;
  localparam logic [7:0] CMD_ISO_SIZE_WR = 8'hAA;
  localparam logic [7:0] CMD_ACK_SIZE_RD = 8'h2B;
  localparam logic [7:0] CMD_ACK_SIZE_WR = 8'hAB;
  localparam logic [7:0] CMD_STATUS_RD = 8'h2C;
  // Reset code and reset values
  localparam logic [15:0] SOFT_RESET_CODE = 16'h00F6;
  localparam logic [15:0] SCRATCH_RST = 16'h0000;
  localparam logic [15:0] ISO_SIZE_RST = 16'h0000;
  localparam logic [15:0] ACK_SIZE_RST = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  // Identity word, value arbitrary
  localparam logic [15:0] IDENTITY_DEFAULT = 16'h5A01;
  // Status field positions
  localparam int FIRST_ISO_LOADED_BIT = 0;
  localparam int SECOND_ISO_LOADED_BIT = 1;
  localparam int ACK_BUFFER_LOADED_BIT = 2;
  localparam int FIRST_ISO_CONSUMED_BIT = 3;
  localparam int SECOND_ISO_CONSUMED_BIT = 4;
  localparam int ACK_BUFFER_CONSUMED_BIT = 5;
  // Total buffer memory in bytes
  localparam logic [15:0] BUFFER_MEM_BYTES = 16'h1000;
endpackage

// file: rtl/buffer_partition.sv
/*
  Buffer memory partition: base addresses of the three regions.
  Assumes the host driver keeps the total within buffer memory.
*/
`timescale 1ns/10ps
module buffer_partition
  import hostmisc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Programmed sizes
  input wire logic [15:0] iso_size_i,
  input wire logic [15:0] ack_size_i,
  // Region bases
  output logic [ADDR_W-1:0] first_iso_base_o,
  output logic [ADDR_W-1:0] second_iso_base_o,
  output logic [ADDR_W-1:0] ack_base_o,
  output logic fits_o
);
  logic [17:0] total;

  // First, second isochronous, then acknowledged list
  assign first_iso_base_o = '0;
  assign second_iso_base_o = iso_size_i[ADDR_W-1:0];
  assign ack_base_o = ADDR_W'({iso_size_i, 1'b0});
  // Overflow check only reported; sizing is the driver's duty
  assign total = 18'({1'b0, iso_size_i, 1'b0}) + 18'(ack_size_i);
  assign fits_o = total <= 18'(BUFFER_MEM_BYTES);
endmodule

// file: rtl/hostmisc_regs.sv
/*
  Miscellaneous and buffer-size register bank of the host engine.
  Holds identity, scratch, soft reset trigger, iso and ack sizes and
  the buffer status word. Assumes a synchronous command port: one
  cycle strobes carry the command code and the write data; events
  from the buffer engine are one-cycle pulses on the same clock.
*/
// What this block does
// - Fixed 16-bit read-only identity word, product high byte, revision low.
// - Scratch word writable and readable back unchanged, zero at reset.
// - Writing F6H to the reset trigger resets all registers, keeps memory.
// - Iso size register sets both iso buffers alike; read/write, zero reset.
// - Ack list size held in 16-bit read/write register, zero at reset.
// - Status word read-only, zero at reset, bits 15 to 6 read zero.
// - Bits 5,4,3 set once ack, second iso, first iso buffer was read.
// - Bits 2,1,0 show ack, second iso, first iso buffer full; clear empty.
`timescale 1ns/10ps
module hostmisc_regs
  import hostmisc_pkg::*;
#(
  parameter logic [15:0] IDENTITY = IDENTITY_DEFAULT,
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Command port
  input wire logic cmd_rd_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] wr_data_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  // Buffer engine events, one-cycle pulses
  input wire logic [2:0] buf_loaded_set_i,
  input wire logic [2:0] buf_emptied_i,
  input wire logic [2:0] buf_consumed_i,
  input wire logic [2:0] buf_consumed_clr_i,
  // Configuration to the buffer engine
  output logic [15:0] iso_size_o,
  output logic [15:0] ack_size_o,
  output logic [ADDR_W-1:0] first_iso_base_o,
  output logic [ADDR_W-1:0] second_iso_base_o,
  output logic [ADDR_W-1:0] ack_base_o,
  output logic sizes_fit_o,
  output logic soft_reset_o
);
  logic [15:0] scratch_q;
  logic [15:0] scratch_d;
  logic [15:0] iso_q;
  logic [15:0] iso_d;
  logic [15:0] ack_q;
  logic [15:0] ack_d;
  logic [2:0] loaded_q;
  logic [2:0] loaded_d;
  logic [2:0] consumed_q;
  logic [2:0] consumed_d;
  logic [15:0] status_word;
  logic [15:0] rd_data_d;
  logic [ADDR_W-1:0] first_base;
  logic [ADDR_W-1:0] second_base;
  logic [ADDR_W-1:0] ack_base;
  logic fits;
  logic soft_rst_q;

  // Strobe and code compare, shared by every write decode
  function automatic logic cmd_hit(
    input logic strobe,
    input logic [7:0] code,
    input logic [7:0] want
  );
    cmd_hit = strobe && (code == want);
  endfunction

  // Set beats clear, so an event is never lost to a clear in its cycle
  function automatic logic [2:0] flag_next(
    input logic [2:0] cur,
    input logic [2:0] set_v,
    input logic [2:0] clr_v
  );
    flag_next = (cur & ~clr_v) | set_v;
  endfunction

  wire logic wr_scratch = cmd_hit(cmd_wr_i, cmd_code_i, CMD_SCRATCH_WR);
  wire logic wr_iso = cmd_hit(cmd_wr_i, cmd_code_i, CMD_ISO_SIZE_WR);
  wire logic wr_ack = cmd_hit(cmd_wr_i, cmd_code_i, CMD_ACK_SIZE_WR);
  wire logic wr_trigger = cmd_hit(cmd_wr_i, cmd_code_i, CMD_SOFT_RESET_WR);
  // Only the exact 16-bit code resets; other values are dropped
  wire logic soft_rst = wr_trigger && wr_data_i == SOFT_RESET_CODE;

  // Soft reset restores defaults; buffer memory lies outside this block
  assign scratch_d = soft_rst ? SCRATCH_RST
    : wr_scratch ? wr_data_i : scratch_q;
  assign iso_d = soft_rst ? ISO_SIZE_RST
    : wr_iso ? wr_data_i : iso_q;
  assign ack_d = soft_rst ? ACK_SIZE_RST
    : wr_ack ? wr_data_i : ack_q;
  assign loaded_d = soft_rst ? STATUS_RST[2:0]
    : flag_next(loaded_q, buf_loaded_set_i, buf_emptied_i);
  assign consumed_d = soft_rst ? STATUS_RST[5:3]
    : flag_next(consumed_q, buf_consumed_i, buf_consumed_clr_i);

  // Reserved bits keep their reset value of zero
  always_comb begin
    status_word = STATUS_RST;
    status_word[FIRST_ISO_LOADED_BIT] = loaded_q[0];
    status_word[SECOND_ISO_LOADED_BIT] = loaded_q[1];
    status_word[ACK_BUFFER_LOADED_BIT] = loaded_q[2];
    status_word[FIRST_ISO_CONSUMED_BIT] = consumed_q[0];
    status_word[SECOND_ISO_CONSUMED_BIT] = consumed_q[1];
    status_word[ACK_BUFFER_CONSUMED_BIT] = consumed_q[2];
  end

  always_comb begin
    case (cmd_code_i)
      CMD_ID_RD: rd_data_d = IDENTITY;
      CMD_SCRATCH_RD: rd_data_d = scratch_q;
      CMD_ISO_SIZE_RD: rd_data_d = iso_q;
      CMD_ACK_SIZE_RD: rd_data_d = ack_q;
      CMD_STATUS_RD: rd_data_d = status_word;
      default: rd_data_d = 16'h0000;
    endcase
  end

  buffer_partition #(
    .ADDR_W(ADDR_W)
  ) u_part (
    .iso_size_i(iso_q),
    .ack_size_i(ack_q),
    .first_iso_base_o(first_base),
    .second_iso_base_o(second_base),
    .ack_base_o(ack_base),
    .fits_o(fits)
  );

  // Scratch word, the driver's own store
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scratch_q <= SCRATCH_RST;
    end else if (clk_en_i) begin
      scratch_q <= scratch_d;
    end
  end

  // One iso size serves both iso buffers
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      iso_q <= ISO_SIZE_RST;
    end else if (clk_en_i) begin
      iso_q <= iso_d;
    end
  end

  // Ack list size
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= ACK_SIZE_RST;
    end else if (clk_en_i) begin
      ack_q <= ack_d;
    end
  end

  // Full flags
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      loaded_q <= STATUS_RST[2:0];
    end else if (clk_en_i) begin
      loaded_q <= loaded_d;
    end
  end

  // Done flags
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      consumed_q <= STATUS_RST[5:3];
    end else if (clk_en_i) begin
      consumed_q <= consumed_d;
    end
  end

  // Trigger seen; held one cycle so the pulse leaves from a flop
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      soft_rst_q <= 1'b0;
    end else if (clk_en_i) begin
      soft_rst_q <= soft_rst;
    end
  end

  // Read answer registered so the port sees no decode glitches
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 16'h0000;
      rd_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      rd_data_o <= cmd_rd_i ? rd_data_d : 16'h0000;
      rd_valid_o <= cmd_rd_i;
    end
  end

  // Configuration copies lag the registers by one cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      iso_size_o <= ISO_SIZE_RST;
      ack_size_o <= ACK_SIZE_RST;
      first_iso_base_o <= '0;
      second_iso_base_o <= '0;
      ack_base_o <= '0;
      sizes_fit_o <= 1'b1;
    end else if (clk_en_i) begin
      iso_size_o <= iso_q;
      ack_size_o <= ack_q;
      first_iso_base_o <= first_base;
      second_iso_base_o <= second_base;
      ack_base_o <= ack_base;
      sizes_fit_o <= fits;
    end
  end

  // Soft reset pulse, two edges after the trigger write
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      soft_reset_o <= 1'b0;
    end else if (clk_en_i) begin
      soft_reset_o <= soft_rst_q;
    end
  end
endmodule

// file: tb/hostmisc_regs_properties.sv
/* Port checker for the register bank.
   Assumes the default identity word and one clock. */
`timescale 1ns/10ps
module hostmisc_regs_properties
  import hostmisc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Inputs
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic cmd_rd_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] wr_data_i,
  // Outputs
  input wire logic [15:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic [15:0] iso_size_o,
  input wire logic [15:0] ack_size_o,
  input wire logic [ADDR_W-1:0] first_iso_base_o,
  input wire logic [ADDR_W-1:0] second_iso_base_o,
  input wire logic [ADDR_W-1:0] ack_base_o,
  input wire logic soft_reset_o
);
  wire rd = cmd_rd_i && clk_en_i;
  wire wr = cmd_wr_i && clk_en_i;
  wire rst_wr = wr && cmd_code_i == CMD_SOFT_RESET_WR;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  chk_rd_answer: assert property (rd_valid_o ==
    ($past(clk_en_i) ? $past(cmd_rd_i) : $past(rd_valid_o)))
    else $error("read answer wrong");
  chk_id_value: assert property (rd && cmd_code_i == CMD_ID_RD |=>
    rd_data_o == IDENTITY_DEFAULT) else $error("identity wrong");
  chk_status_resv: assert property (rd && cmd_code_i == CMD_STATUS_RD
    |=> rd_data_o[15:6] == 10'h000) else $error("reserved bits set");
  chk_iso_copy: assert property (wr && cmd_code_i == CMD_ISO_SIZE_WR
    |-> ##2 iso_size_o == $past(wr_data_i, 2)) else $error("iso size");
  chk_ack_copy: assert property (wr && cmd_code_i == CMD_ACK_SIZE_WR
    |-> ##2 ack_size_o == $past(wr_data_i, 2)) else $error("ack size");
  chk_soft_reset: assert property (rst_wr && wr_data_i == SOFT_RESET_CODE
    |-> ##2 soft_reset_o && iso_size_o == 16'h0000 && ack_size_o == 16'h0000)
    else $error("soft reset missing");
  chk_bad_code: assert property (rst_wr && wr_data_i != SOFT_RESET_CODE
    |-> ##2 !soft_reset_o && $stable(iso_size_o)) else $error("bad code acted");
  chk_base_split: assert property (first_iso_base_o == '0 &&
    ack_base_o == second_iso_base_o << 1) else $error("bases wrong");
endmodule
bind hostmisc_regs hostmisc_regs_properties #(.ADDR_W(ADDR_W)) i_props (
  .clk_sys_i, .reset_n_i, .clk_en_i, .cmd_rd_i, .cmd_wr_i, .cmd_code_i,
  .wr_data_i, .rd_data_o, .rd_valid_o, .iso_size_o, .ack_size_o,
  .first_iso_base_o, .second_iso_base_o, .ack_base_o, .soft_reset_o);

// file: tb/host_model.sv
/* Host processor model issuing command strobes.
   Assumes the one-cycle answer of the command port. */
`timescale 1ns/10ps
module host_model (
  // Answer
  input wire logic clk_sys_i,
  input wire logic rd_valid_o,
  input wire logic [15:0] rd_data_o,
  // Strobes, named after the pins they drive
  output logic cmd_rd_i = 0,
  output logic cmd_wr_i = 0,
  output logic [7:0] cmd_code_i = 8'h00,
  output logic [15:0] wr_data_i = 16'h0000
);
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys_i) #1;
    {cmd_wr_i, cmd_code_i, wr_data_i} = {1'b1, c, d};
    @(posedge clk_sys_i) #1;
    cmd_wr_i = 0;
    wr_data_i = ~d; // Stale data must not look valid
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk_sys_i) #1;
    {cmd_rd_i, cmd_code_i} = {1'b1, c};
    @(posedge clk_sys_i) #1;
    cmd_rd_i = 0;
    d = rd_valid_o ? rd_data_o : 16'hXXXX;
  endtask
endmodule

// file: tb/testbench.sv
/* Scenario bench for the register bank.
   Assumes the host model and checker files. */
`timescale 1ns/10ps
module testbench;
  import hostmisc_pkg::*;
  logic clk_sys_i = 0, reset_n_i = 0, clk_en_i = 1;
  logic cmd_rd_i, cmd_wr_i, rd_valid_o, sizes_fit_o, soft_reset_o;
  logic [7:0] cmd_code_i;
  logic [15:0] wr_data_i, rd_data_o, iso_size_o, ack_size_o, b0, b1, b2;
  logic [2:0] ld = 0, em = 0, co = 0, cc = 0;
  int err_count = 0, n_tests = 0, cyc = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  hostmisc_regs i_hostmisc_regs (.clk_sys_i, .reset_n_i, .clk_en_i,
    .cmd_rd_i, .cmd_wr_i, .cmd_code_i, .wr_data_i, .rd_data_o, .rd_valid_o,
    .buf_loaded_set_i(ld), .buf_emptied_i(em), .buf_consumed_i(co),
    .buf_consumed_clr_i(cc), .iso_size_o, .ack_size_o,
    .first_iso_base_o(b0), .second_iso_base_o(b1), .ack_base_o(b2),
    .sizes_fit_o, .soft_reset_o);
  host_model i_host_model (.clk_sys_i, .rd_valid_o, .rd_data_o, .cmd_rd_i,
    .cmd_wr_i, .cmd_code_i, .wr_data_i);
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %0t got %h expected %h", $time, g, e);
    end
  endtask
  task rdc(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] d;
    i_host_model.rd(c, d);
    chk(d, e);
  endtask
  task ev(input logic [11:0] v);
    @(posedge clk_sys_i) #1;
    {ld, em, co, cc} = v;
    @(posedge clk_sys_i) #1;
    {ld, em, co, cc} = 12'h000;
  endtask
  task print_verdict;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 3000) begin
      err_count++;
      print_verdict;
    end
  end
  task test_reset_values;
    rdc(CMD_ID_RD, IDENTITY_DEFAULT);
    rdc(CMD_STATUS_RD, STATUS_RST);
    rdc(8'h2D, 16'h0000);
    chk({15'h0, sizes_fit_o}, 16'h0001);
    $display("test reset values done");
  endtask
  task test_scratch;
    i_host_model.wr(CMD_SCRATCH_WR, 16'hA55A);
    rdc(CMD_SCRATCH_RD, 16'hA55A);
    @(posedge clk_sys_i) #1;
    clk_en_i = 0; // Frozen cycle: this write must be lost
    i_host_model.wr(CMD_SCRATCH_WR, 16'h1234);
    clk_en_i = 1;
    rdc(CMD_SCRATCH_RD, 16'hA55A);
    $display("test scratch done");
  endtask
  task test_sizes;
    i_host_model.wr(CMD_ISO_SIZE_WR, 16'h0400);
    i_host_model.wr(CMD_ACK_SIZE_WR, 16'h0800);
    rdc(CMD_ISO_SIZE_RD, 16'h0400);
    chk(iso_size_o, 16'h0400);
    chk(b0, 16'h0000);
    chk(b1, 16'h0400);
    chk(b2, 16'h0800);
    chk({15'h0, sizes_fit_o}, 16'h0001);
    i_host_model.wr(CMD_ACK_SIZE_WR, 16'h0801);
    rdc(CMD_ACK_SIZE_RD, 16'h0801);
    chk(ack_size_o, 16'h0801);
    chk({15'h0, sizes_fit_o}, 16'h0000);
    $display("test sizes done");
  endtask
  task test_status;
    ev(12'hE00);
    rdc(CMD_STATUS_RD, 16'h0007);
    // Ack done set and cleared in one cycle: the set must win
    ev(12'h02C);
    rdc(CMD_STATUS_RD, 16'h002F);
    ev(12'h4D4);
    rdc(CMD_STATUS_RD, 16'h001E);
    $display("test status done");
  endtask
  task test_soft_reset;
    i_host_model.wr(CMD_SOFT_RESET_WR, 16'h01F6);
    rdc(CMD_SCRATCH_RD, 16'hA55A);
    rdc(CMD_ACK_SIZE_RD, 16'h0801);
    i_host_model.wr(CMD_SOFT_RESET_WR, SOFT_RESET_CODE);
    rdc(CMD_SCRATCH_RD, SCRATCH_RST);
    rdc(CMD_ISO_SIZE_RD, ISO_SIZE_RST);
    rdc(CMD_ACK_SIZE_RD, ACK_SIZE_RST);
    rdc(CMD_STATUS_RD, STATUS_RST);
    chk({15'h0, sizes_fit_o}, 16'h0001);
    $display("test soft reset done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    #1 reset_n_i = 1;
    test_reset_values;
    test_scratch;
    test_sizes;
    test_status;
    test_soft_reset;
    print_verdict;
  end
endmodule
